//--- rtl/epmc_pkg.sv
/*
 * Package for the exception priority and mask control block: pseudo register
 * numbers, exception classes, priority codes and packed carriers.
 * Assumes special register numbers arrive as 10-bit decimal indices.
 */
package epmc_pkg;

    // Pseudo special register numbers (decimal 80, 81, 82)
    localparam logic [9:0] SPR_INT_ENABLE = 10'h050;
    localparam logic [9:0] SPR_INT_DISABLE = 10'h051;
    localparam logic [9:0] SPR_NONRECOV = 10'h052;

    // Priority codes, 1 is highest
    localparam logic [2:0] PRIO_NONE = 3'h0;
    localparam logic [2:0] PRIO_NMI_BKPT = 3'h1;
    localparam logic [2:0] PRIO_RESET = 3'h2;
    localparam logic [2:0] PRIO_SYNC = 3'h3;
    localparam logic [2:0] PRIO_MASK_BKPT = 3'h4;
    localparam logic [2:0] PRIO_EXT_IRQ = 3'h5;
    localparam logic [2:0] PRIO_DECR = 3'h6;

    // Reset values of the two mask bits
    localparam logic EE_RESET = 1'b0;
    localparam logic RI_RESET = 1'b0;

    typedef enum logic [2:0] {
        EPMC_EXC_NONE,
        EPMC_EXC_NMI_BKPT,
        EPMC_EXC_RESET,
        EPMC_EXC_SYNC,
        EPMC_EXC_MASK_BKPT,
        EPMC_EXC_EXT_IRQ,
        EPMC_EXC_DECR,
        EPMC_EXC_SW_EMUL
    } epmc_exc_t;

    // Special register access from the pipeline
    typedef struct packed {
        logic valid;
        logic isWrite;
        logic [9:0] sprNum;
        logic [31:0] data;
    } epmc_spr_req_t;

    // State of the instruction at the head of the history buffer
    typedef struct packed {
        logic valid;
        logic completed;
        logic hasException;
        logic mayFinish;
    } epmc_head_t;

endpackage

//--- rtl/epmc_exception_unit.sv
/*
 * Exception arbiter and external-interrupt / recoverable mask control.
 * Assumes asynchronous sources arrive as levels from pins, the pipeline and
 * history buffer signals are on ref_clk, and the pipeline stalls the next
 * instruction until excTake answers a pending asynchronous cause.
 */
// Functional notes
// [RULE_01] Write to pseudo register 80 sets interrupt enable and recoverable flag.
// [RULE_02] Write to pseudo register 81 clears interrupt enable, sets recoverable flag.
// [RULE_03] Write to pseudo register 82 clears interrupt enable and recoverable flag.
// [RULE_04] Pseudo register writes act on the address alone, data ignored.
// [RULE_05] Reads of pseudo registers raise a software emulation exception.
// [RULE_06] Only the highest priority pending exception is taken.
// [RULE_07] Non-maskable asynchronous exceptions are taken without waiting.
// [RULE_08] Instruction-caused exceptions are handled in program order.
// [RULE_09] Maskable asynchronous exceptions wait for the head instruction's own exception.
// [RULE_10] Non-maskable breakpoint is priority 1, taken regardless of recoverability.
// [RULE_11] Reset is priority 2, below only the non-maskable breakpoint.
// [RULE_12] Instruction exception is priority 3, raised at the buffer head.
// [RULE_13] Maskable breakpoint is priority 4, retire then flush or retire head.
// [RULE_14] External interrupt is priority 5, held while enable bit is clear.
// [RULE_15] Decrementer is lowest, priority 6, held while enable bit is clear.
// [RULE_16] Taking any exception clears the interrupt enable bit.
// [RULE_17] Recoverable flag is saved to the status copy, then cleared.
// [RULE_18] Async exception goes to head; finishable head completes, else flush.
// [RULE_19] Mask changes govern the instruction right after the write.
`timescale 1ns/1ps

module epmc_exception_unit #(
    parameter int SYNC_STAGES = 3
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire epmc_pkg::epmc_spr_req_t sprReq,
    input wire epmc_pkg::epmc_head_t headInfo,
    input wire logic nmiBreakPin,
    input wire logic resetReqPin,
    input wire logic maskBreakPin,
    input wire logic extIrqPin,
    input wire logic decrPin,
    output logic excTake_q,
    output epmc_pkg::epmc_exc_t excCause_q,
    output logic [2:0] excPrio_q,
    output logic flushHead_q,
    output logic retireHead_q,
    output logic extIrqEnable_q,
    output logic recoverable_q,
    output logic savedRecoverable_q,
    output logic sprReadFault_q
);

    // Synchroniser chains for the five asynchronous pins
    logic [4:0] pinRaw;
    logic [4:0] syncStage [SYNC_STAGES];
    logic [4:0] pinLevel_q;
    logic [4:0] pinLevel_d;

    assign pinRaw = {decrPin, extIrqPin, maskBreakPin, resetReqPin, nmiBreakPin};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_STAGES; gi++) begin : gSync
            if (gi == 0) begin : gFirst
                // First stage samples the raw pins
                always_ff @(posedge ref_clk) begin
                    if (!rstn) begin
                        syncStage[gi] <= '0;
                    end else begin
                        syncStage[gi] <= pinRaw;
                    end
                end
            end else begin : gNext
                // Later stages follow the one before
                always_ff @(posedge ref_clk) begin
                    if (!rstn) begin
                        syncStage[gi] <= '0;
                    end else begin
                        syncStage[gi] <= syncStage[gi - 1];
                    end
                end
            end
        end
    endgenerate

    // A level change counts once the last two stages agree
    always_comb begin
        for (int b = 0; b < 5; b++) begin
            if (syncStage[SYNC_STAGES - 1][b] == syncStage[SYNC_STAGES - 2][b]) begin
                pinLevel_d[b] = syncStage[SYNC_STAGES - 1][b];
            end else begin
                pinLevel_d[b] = pinLevel_q[b];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pinLevel_q <= '0;
        end else begin
            pinLevel_q <= pinLevel_d;
        end
    end

    // Decoded pseudo register accesses
    logic wrEnable;
    logic wrDisable;
    logic wrNonRecov;
    logic rdPseudo;
    logic pseudoHit;

    always_comb begin
        pseudoHit = 1'b0;
        if (sprReq.sprNum == epmc_pkg::SPR_INT_ENABLE) begin
            pseudoHit = 1'b1;
        end else if (sprReq.sprNum == epmc_pkg::SPR_INT_DISABLE) begin
            pseudoHit = 1'b1;
        end else if (sprReq.sprNum == epmc_pkg::SPR_NONRECOV) begin
            pseudoHit = 1'b1;
        end
    end

    // Only the address selects the action; sprReq.data is never looked at
    assign wrEnable = sprReq.valid && sprReq.isWrite && (sprReq.sprNum == epmc_pkg::SPR_INT_ENABLE); // [RULE_04]
    assign wrDisable = sprReq.valid && sprReq.isWrite && (sprReq.sprNum == epmc_pkg::SPR_INT_DISABLE); // [RULE_04]
    assign wrNonRecov = sprReq.valid && sprReq.isWrite && (sprReq.sprNum == epmc_pkg::SPR_NONRECOV); // [RULE_04]
    assign rdPseudo = sprReq.valid && !sprReq.isWrite && pseudoHit; // [RULE_05]

    // Pending causes by priority
    logic nmiPend;
    logic resetPend;
    logic syncPend;
    logic maskBkPend;
    logic extPend;
    logic decrPend;
    logic headReady;
    logic [4:0] pinActive;

    // Head is settled once any exception it carries can be taken first
    assign headReady = !headInfo.valid || headInfo.completed || headInfo.hasException; // [RULE_09]
    assign nmiPend = pinActive[0]; // [RULE_07] [RULE_10]
    assign resetPend = pinActive[1]; // [RULE_11]
    // Apart from a pseudo register read fault, only the head instruction may raise its exception, keeping program order
    assign syncPend = (headInfo.valid && headInfo.hasException) || sprReadFault_q; // [RULE_08] [RULE_12]
    assign maskBkPend = pinActive[2] && headReady; // [RULE_13]
    assign extPend = pinActive[3] && extIrqEnable_q && headReady; // [RULE_14]
    assign decrPend = pinActive[4] && extIrqEnable_q && headReady; // [RULE_15]

    // Fixed priority select of a single winner
    epmc_pkg::epmc_exc_t winCause;
    logic [2:0] winPrio;

    always_comb begin
        winCause = epmc_pkg::EPMC_EXC_NONE;
        winPrio = epmc_pkg::PRIO_NONE;
        if (nmiPend) begin
            winCause = epmc_pkg::EPMC_EXC_NMI_BKPT; // [RULE_06] [RULE_10]
            winPrio = epmc_pkg::PRIO_NMI_BKPT;
        end else if (resetPend) begin
            winCause = epmc_pkg::EPMC_EXC_RESET; // [RULE_11]
            winPrio = epmc_pkg::PRIO_RESET;
        end else if (syncPend) begin
            if (sprReadFault_q && !(headInfo.valid && headInfo.hasException)) begin
                winCause = epmc_pkg::EPMC_EXC_SW_EMUL; // [RULE_05]
            end else begin
                winCause = epmc_pkg::EPMC_EXC_SYNC; // [RULE_12]
            end
            winPrio = epmc_pkg::PRIO_SYNC;
        end else if (maskBkPend) begin
            winCause = epmc_pkg::EPMC_EXC_MASK_BKPT; // [RULE_13]
            winPrio = epmc_pkg::PRIO_MASK_BKPT;
        end else if (extPend) begin
            winCause = epmc_pkg::EPMC_EXC_EXT_IRQ; // [RULE_14]
            winPrio = epmc_pkg::PRIO_EXT_IRQ;
        end else if (decrPend) begin
            winCause = epmc_pkg::EPMC_EXC_DECR; // [RULE_15]
            winPrio = epmc_pkg::PRIO_DECR;
        end
    end

    logic takeNow;
    logic asyncMaskable;
    assign takeNow = (winCause != epmc_pkg::EPMC_EXC_NONE) && !excTake_q;
    assign asyncMaskable = (winPrio == epmc_pkg::PRIO_MASK_BKPT) || (winPrio == epmc_pkg::PRIO_EXT_IRQ) ||
        (winPrio == epmc_pkg::PRIO_DECR);

    // Which pin source the current take answers
    logic [4:0] pinTaken;
    logic [4:0] pinServed_q;

    always_comb begin
        pinTaken = '0;
        if (takeNow) begin
            if (winCause == epmc_pkg::EPMC_EXC_NMI_BKPT) begin
                pinTaken[0] = 1'b1;
            end else if (winCause == epmc_pkg::EPMC_EXC_RESET) begin
                pinTaken[1] = 1'b1;
            end else if (winCause == epmc_pkg::EPMC_EXC_MASK_BKPT) begin
                pinTaken[2] = 1'b1;
            end else if (winCause == epmc_pkg::EPMC_EXC_EXT_IRQ) begin
                pinTaken[3] = 1'b1;
            end else if (winCause == epmc_pkg::EPMC_EXC_DECR) begin
                pinTaken[4] = 1'b1;
            end
        end
    end

    // A taken level stays masked until its synchronised copy falls, so the
    // synchroniser latency cannot cause a second take of the same request
    generate
        for (gi = 0; gi < 5; gi++) begin : gServed
            // Set by the take, cleared by the falling level; set wins
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    pinServed_q[gi] <= 1'b0;
                end else if (pinTaken[gi]) begin
                    pinServed_q[gi] <= 1'b1;
                end else if (!pinLevel_q[gi]) begin
                    pinServed_q[gi] <= 1'b0;
                end
            end
            assign pinActive[gi] = pinLevel_q[gi] && !pinServed_q[gi];
        end
    endgenerate

    // Take pulse, cause and priority of the exception
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            excTake_q <= 1'b0;
            excCause_q <= epmc_pkg::EPMC_EXC_NONE;
            excPrio_q <= epmc_pkg::PRIO_NONE;
        end else begin
            excTake_q <= takeNow; // [RULE_06]
            if (takeNow) begin
                excCause_q <= winCause;
                excPrio_q <= winPrio;
            end
        end
    end

    // Head disposal for a taken cause; only an asynchronous cause can retire the head
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            flushHead_q <= 1'b0;
            retireHead_q <= 1'b0;
        end else begin
            flushHead_q <= 1'b0;
            retireHead_q <= 1'b0;
            if (takeNow && headInfo.valid && !headInfo.completed) begin
                if ((asyncMaskable || winPrio == epmc_pkg::PRIO_NMI_BKPT || winPrio == epmc_pkg::PRIO_RESET)
                    && headInfo.mayFinish && !headInfo.hasException) begin
                    retireHead_q <= 1'b1; // [RULE_18]
                end else begin
                    flushHead_q <= 1'b1; // [RULE_18]
                end
            end
        end
    end

    // Interrupt enable and recoverable flag; an exception outranks a command
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            extIrqEnable_q <= epmc_pkg::EE_RESET;
            recoverable_q <= epmc_pkg::RI_RESET;
            savedRecoverable_q <= epmc_pkg::RI_RESET;
        end else if (takeNow) begin
            savedRecoverable_q <= recoverable_q; // [RULE_17]
            recoverable_q <= 1'b0; // [RULE_17]
            extIrqEnable_q <= 1'b0; // [RULE_16]
        end else if (wrEnable) begin
            extIrqEnable_q <= 1'b1; // [RULE_01] [RULE_19]
            recoverable_q <= 1'b1; // [RULE_01]
        end else if (wrDisable) begin
            extIrqEnable_q <= 1'b0; // [RULE_02] [RULE_19]
            recoverable_q <= 1'b1; // [RULE_02]
        end else if (wrNonRecov) begin
            extIrqEnable_q <= 1'b0; // [RULE_03] [RULE_19]
            recoverable_q <= 1'b0; // [RULE_03]
        end
    end

    // Read fault flag: set wins over the clear by the take
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sprReadFault_q <= 1'b0;
        end else if (rdPseudo) begin
            sprReadFault_q <= 1'b1; // [RULE_05]
        end else if (takeNow && winCause == epmc_pkg::EPMC_EXC_SW_EMUL) begin
            sprReadFault_q <= 1'b0;
        end
    end

endmodule

//--- testbench/epmc_exception_unit_monitor.sv
/* Port checker for the exception unit.
   Assumes one ref_clk domain with synchronous active-low rstn. */
`timescale 1ns/1ps
module epmc_exception_unit_monitor (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire epmc_pkg::epmc_spr_req_t sprReq,
    input wire logic nmiBreakPin,
    input wire logic excTake_q,
    input wire epmc_pkg::epmc_exc_t excCause_q,
    input wire logic [2:0] excPrio_q,
    input wire logic flushHead_q,
    input wire logic retireHead_q,
    input wire logic extIrqEnable_q,
    input wire logic recoverable_q,
    input wire logic savedRecoverable_q,
    input wire logic sprReadFault_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic wr;
    // Valid special register write of any number
    assign wr = sprReq.valid && sprReq.isWrite;
    write_80_a: assert property (wr && sprReq.sprNum == 10'h050 |=> excTake_q || extIrqEnable_q && recoverable_q)
        else $error("enable command result wrong");
    write_81_a: assert property (wr && sprReq.sprNum == 10'h051 |=> !extIrqEnable_q && (excTake_q || recoverable_q))
        else $error("disable command result wrong");
    write_82_a: assert property (wr && sprReq.sprNum == 10'h052 |=> !extIrqEnable_q && !recoverable_q)
        else $error("nonrecoverable command result wrong");
    read_fault_a: assert property (sprReq.valid && !sprReq.isWrite && sprReq.sprNum inside {[10'h050:10'h052]}
        |=> sprReadFault_q) else $error("pseudo read not faulted");
    take_single_a: assert property (excTake_q |=> !excTake_q) else $error("take repeated");
    nmi_fast_a: assert property ($rose(nmiBreakPin) |-> ##[1:8] excTake_q && excCause_q == epmc_pkg::EPMC_EXC_NMI_BKPT)
        else $error("breakpoint not taken at once");
    prio_code_a: assert property (excTake_q |-> excPrio_q == (excCause_q == epmc_pkg::EPMC_EXC_SW_EMUL ?
        epmc_pkg::PRIO_SYNC : 3'(excCause_q))) else $error("priority code wrong");
    ee_gate_a: assert property (excTake_q && excPrio_q >= epmc_pkg::PRIO_EXT_IRQ |-> $past(extIrqEnable_q))
        else $error("masked source taken");
    take_clears_a: assert property (excTake_q |-> !extIrqEnable_q && !recoverable_q)
        else $error("mask bits not cleared on take");
    ri_saved_a: assert property (excTake_q |-> savedRecoverable_q == $past(recoverable_q))
        else $error("recoverable copy wrong");
    head_action_a: assert property (flushHead_q || retireHead_q |-> excTake_q && !(flushHead_q && retireHead_q))
        else $error("head action without single take");
endmodule
bind epmc_exception_unit epmc_exception_unit_monitor epmc_exception_unit_monitor_i (.ref_clk, .rstn, .sprReq,
    .nmiBreakPin, .excTake_q, .excCause_q, .excPrio_q, .flushHead_q, .retireHead_q, .extIrqEnable_q,
    .recoverable_q, .savedRecoverable_q, .sprReadFault_q);

//--- testbench/epmc_source_model.sv
/* Level sources and history buffer head for the exception unit.
   Assumes raise pulses come from the bench; a source drops once its cause is taken. */
`timescale 1ns/1ps
module epmc_source_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [5:0] raise,
    input wire logic excTake_q,
    input wire epmc_pkg::epmc_exc_t excCause_q,
    output logic nmiBreakPin,
    output logic resetReqPin,
    output logic maskBreakPin,
    output logic extIrqPin,
    output logic decrPin,
    output epmc_pkg::epmc_head_t headInfo
);
    logic [5:0] act_q;
    logic [5:0] drop;
    logic [3:0] headDly_q;
    logic [5:0] raiseEff;
    // Head fault is delayed to meet the pins after the design's synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            headDly_q <= 4'h0;
        end else begin
            headDly_q <= {headDly_q[2:0], raise[2]};
        end
    end
    assign raiseEff = {raise[5:3], headDly_q[3], raise[1:0]};
    // Bit n holds the source of cause n+1; software emulation maps to none
    assign drop = excTake_q ? 6'h01 << (3'(excCause_q) - 3'h1) : 6'h00;
    // Sources stay high until their own take is seen
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            act_q <= 6'h00;
        end else begin
            act_q <= (act_q | raiseEff) & ~drop;
        end
    end
    // Pins and an uncompleted faulting head
    assign {decrPin, extIrqPin, maskBreakPin, resetReqPin, nmiBreakPin} = {act_q[5:3], act_q[1:0]};
    assign headInfo = {act_q[2], 1'b0, act_q[2], 1'b0};
endmodule

//--- testbench/tb_epmc_exception_unit.sv
/* Directed bench for the exception unit with the source model.
   Assumes sprReq is sampled at posedge; inputs change at negedge. */
`timescale 1ns/1ps
module tb_epmc_exception_unit;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] raise = 6'h00;
    epmc_pkg::epmc_spr_req_t sprReq = '0;
    epmc_pkg::epmc_head_t headInfo;
    epmc_pkg::epmc_exc_t excCause_q;
    logic nmiBreakPin, resetReqPin, maskBreakPin, extIrqPin, decrPin;
    logic excTake_q, extIrqEnable_q, recoverable_q, sprReadFault_q;
    int n_fail = 0;
    int samples_checked = 0;
    logic [1:0] expBits [3] = '{2'b11, 2'b01, 2'b00};
    epmc_exception_unit epmc_exception_unit_i (.ref_clk(ref_clk), .rstn(rstn), .sprReq(sprReq),
        .headInfo(headInfo), .nmiBreakPin(nmiBreakPin), .resetReqPin(resetReqPin),
        .maskBreakPin(maskBreakPin), .extIrqPin(extIrqPin), .decrPin(decrPin), .excTake_q(excTake_q),
        .excCause_q(excCause_q), .excPrio_q(), .flushHead_q(), .retireHead_q(),
        .extIrqEnable_q(extIrqEnable_q), .recoverable_q(recoverable_q), .savedRecoverable_q(),
        .sprReadFault_q(sprReadFault_q));
    epmc_source_model epmc_source_model_i (.ref_clk(ref_clk), .rstn(rstn), .raise(raise),
        .excTake_q(excTake_q), .excCause_q(excCause_q), .nmiBreakPin(nmiBreakPin),
        .resetReqPin(resetReqPin), .maskBreakPin(maskBreakPin), .extIrqPin(extIrqPin),
        .decrPin(decrPin), .headInfo(headInfo));
    // Clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task check(input logic [2:0] seen, input logic [2:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pseudo register access; held until idle or the next call
    task special_purpose_register(input logic wr, input logic [9:0] num, input logic [31:0] d);
        @(negedge ref_clk);
        sprReq <= {1'b1, wr, num, d};
    endtask
    task idle();
        @(negedge ref_clk);
        sprReq <= '0;
    endtask
    // Wait for a take and compare its cause; NONE expects no take
    task take(input epmc_pkg::epmc_exc_t c);
        for (int i = 0; i < 40 && excTake_q !== 1'b1; i++) @(negedge ref_clk);
        check(excTake_q === 1'b1 ? excCause_q : 3'h0, c);
        @(negedge ref_clk);
    endtask
    task finish_test();
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #20000;
        n_fail++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(negedge ref_clk);
        check({excTake_q, extIrqEnable_q, recoverable_q}, 3'h0);
        for (int i = 0; i < 6; i++) begin
            special_purpose_register(1'b1, 10'h050 + 10'(i % 3), i < 3 ? 32'hffff_ffff : 32'h0000_0000);
            idle();
            check({1'b0, extIrqEnable_q, recoverable_q}, {1'b0, expBits[i % 3]});
        end
        special_purpose_register(1'b1, 10'h052, 32'h0000_0000);
        special_purpose_register(1'b1, 10'h050, 32'h0000_0000);
        idle();
        check({1'b0, extIrqEnable_q, recoverable_q}, 3'h3);
        special_purpose_register(1'b0, 10'h051, 32'h0000_0000);
        idle();
        check(sprReadFault_q, 1'b1);
        take(epmc_pkg::EPMC_EXC_SW_EMUL);
        special_purpose_register(1'b1, 10'h050, 32'h0000_0000);
        idle();
        raise <= 6'h3f;
        @(negedge ref_clk);
        raise <= 6'h00;
        take(epmc_pkg::EPMC_EXC_NMI_BKPT);
        take(epmc_pkg::EPMC_EXC_RESET);
        take(epmc_pkg::EPMC_EXC_SYNC);
        take(epmc_pkg::EPMC_EXC_MASK_BKPT);
        take(epmc_pkg::EPMC_EXC_NONE);
        special_purpose_register(1'b1, 10'h050, 32'h0000_0000);
        idle();
        take(epmc_pkg::EPMC_EXC_EXT_IRQ);
        special_purpose_register(1'b1, 10'h051, 32'h0000_0000);
        idle();
        take(epmc_pkg::EPMC_EXC_NONE);
        special_purpose_register(1'b1, 10'h050, 32'h0000_0000);
        idle();
        take(epmc_pkg::EPMC_EXC_DECR);
        finish_test();
    end
endmodule
